/* File: common/mixed_io_consts.svh */
// constants of the mixed input/output process image: object codes, bit positions, codes
`ifndef MIXED_IO_CONSTS_SVH
`define MIXED_IO_CONSTS_SVH

// process-data object codes the controller may select
`define OBJ_NONE 16'h0000
`define OBJ_IN_BYTE 16'h1A00
`define OBJ_IN_BIT 16'h1A01
`define OBJ_MIR_BYTE 16'h1A02
`define OBJ_MIR_BIT 16'h1A03
`define OBJ_ERR 16'h1A04
`define OBJ_DIAG 16'h1A05
`define OBJ_OUT_BYTE 16'h1600
`define OBJ_OUT_BIT 16'h1601

// error byte codes
`define ERR_NONE 8'h00
`define ERR_OVERLOAD 8'h03
`define ERR_VOLTAGE 8'h05
`define ERR_DEVICE 8'h81

// module flag positions in diagnostic byte 1
`define DIAG_LOW_SYS_BIT 0
`define DIAG_LOW_ACT_BIT 1
`define DIAG_SENSOR_SHORT_BIT 2
`define DIAG_ACT_SHORT_BIT 3
`define DIAG_FORCING_BIT 6
`define DIAG_INTERNAL_BIT 7

// fixed content of diagnostic byte 3
`define DIAG_BYTE3_VALUE 8'h00

// image geometry: input byte + mirror byte + error byte + four diagnostic bytes
`define IMAGE_BYTES 7
`define LEN_W 3
`define CHANNELS 8

// output command after reset: all channels off
`define RST_OUT_CMD 8'h00

`endif

/* File: common/mixed_io_pkg.sv */
// types shared by the mixed input/output process-image logic
`include "mixed_io_consts.svh"

package mixed_io_pkg;

    typedef enum logic {
        FMT_BYTE = 1'b0,
        FMT_BIT = 1'b1
    } format_t;

    typedef enum logic [1:0] {
        MIR_NONE = 2'b00,
        MIR_BYTE = 2'b01,
        MIR_BIT = 2'b10
    } mirror_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_APPLY = 2'b01,
        ST_PUBLISH = 2'b10
    } state_t;

    // mapping request from the controller, as object codes
    typedef struct packed {
        logic [15:0] inObj;
        logic [15:0] mirObj;
        logic errEn;
        logic diagEn;
        logic [15:0] outObj;
    } cfg_t;

    // fault and status levels; chanErr bit0 = X5 A ... bit7 = X8 B
    typedef struct packed {
        logic lowSys;
        logic lowAct;
        logic forcing;
        logic internal;
        logic [7:0] sensorShortSlot;
        logic [7:0] chanErr;
    } fault_t;

    // every pin-side level, synchronised as one bundle
    typedef struct packed {
        logic [7:0] inPins;
        logic [7:0] outFeedback;
        fault_t fault;
    } pins_t;

    typedef logic [`IMAGE_BYTES-1:0][7:0] image_t;

    typedef struct packed {
        image_t img;
        logic [`LEN_W-1:0] len;
    } frame_t;

    // complete state of the process-image core
    typedef struct packed {
        state_t st;
        format_t inFmt;
        mirror_t mir;
        logic errEn;
        logic diagEn;
        format_t outFmt;
        logic [7:0] cmd;
        logic [7:0] chanOut;
        logic [7:0] errCode;
        logic [31:0] diag;
        image_t img;
        logic [`LEN_W-1:0] len;
        logic txValid;
        logic cfgAccept;
        logic cfgReject;
    } core_t;

endpackage

/* File: rtl/pin_sync.sv */
// two-stage synchroniser for a bundle of pin levels
`timescale 1ns/1ps

module pin_sync #(
    parameter int WIDTH = 1
) (
    // clock, reset, enable
    input wire logic mclk,
    input wire logic rstSync_n,
    input wire logic ce,
    // levels
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);

    typedef struct packed {
        logic [WIDTH-1:0] stage2;
        logic [WIDTH-1:0] stage1;
    } sync_t;

    sync_t state_q;
    sync_t state_d;

    generate
        if (WIDTH < 1) begin : g_bad_width
            $error("pin_sync needs a width of at least one");
        end
    endgenerate

    // stage1 feeds only stage2, so metastability never reaches logic
    always_comb begin
        state_d = state_q;
        if (ce) begin
            state_d.stage1 = asyncIn;
            state_d.stage2 = state_q.stage1;
        end
    end

    always_ff @(posedge mclk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign syncOut = state_q.stage2;

endmodule // pin_sync

/* File: rtl/mixed_io_process_image.sv */
// process-image core of a mixed 8-input / 8-output field module
//
// Overview of operation
// - controller picks byte or bit input object; both forms report the same input byte
// - byte input: bit0 X1 A, bit1 X1 B, ... bit7 X4 B
// - bit input: same byte as byte input, X1 A in bit0 through X4 B in bit7
// - byte mirror: real output states, bit0 X5 A ... bit7 X8 B
// - bit mirror: same real output byte as byte mirror, X5 A in bit0 through X8 B in bit7, sent inward
// - error byte and diagnostic word are appended when selected
// - error byte zero without fault; short circuit gives bits 0 and 1
// - low system or actuator supply gives error bits 0 and 2
// - forcing or internal fault gives error bits 0 and 7
// - diagnostic byte 1 holds module flags; bits 4 and 5 zero
// - any slot sensor short raises flag; byte 2 holds per-slot flags
// - diagnostic byte 3 zero; byte 4 holds X5..X8 channel errors
// - low actuator and low system supply flags are raised separately
// - any actuator short raises its flag and the overload code
// - internal fault raises its flag and the device error code
// - controller picks byte or bit output object for X5..X8 commands
// - byte output: bit0 drives X5 A ... bit7 drives X8 B
`timescale 1ns/1ps
`include "mixed_io_consts.svh"

module mixed_io_process_image #(
    parameter int CHANNELS = `CHANNELS
) (
    // clock, reset, enable
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ce,
    // mapping selection from the controller
    input wire logic cfgWrite,
    input wire mixed_io_pkg::cfg_t cfgIn,
    output logic cfgAccept,
    output logic cfgReject,
    // cyclic process data
    input wire logic pdStrobe,
    input wire logic [7:0] outByte,
    input wire logic [7:0] outBitMask,
    output logic txValid,
    output mixed_io_pkg::image_t txImage,
    output logic [`LEN_W-1:0] txLength,
    // live status
    output logic [7:0] errorCode,
    output logic [31:0] diagWord,
    // field pins
    input wire logic [7:0] inPins,
    input wire logic [7:0] outFeedback,
    input wire mixed_io_pkg::fault_t faultPins,
    output logic [7:0] chanOut
);

    ////////////////////////////////////////////////////////////////////////////////
    // elaboration checks and reset release

    generate
        if (CHANNELS != 8) begin : g_bad_channels
            $error("process image supports exactly eight channels per direction");
        end
        // the length field must count up to a full image of every object
        if ((1 << `LEN_W) <= `IMAGE_BYTES) begin : g_bad_length
            $error("length field too narrow for a full image");
        end
    endgenerate

    // reset pipe is not gated by ce, so a frozen block still leaves reset
    logic [1:0] rstPipe_q;
    logic rstSync_n;

    // release is synchronised, assertion stays immediate
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rstPipe_q <= 2'b00;
        end else begin
            rstPipe_q <= {rstPipe_q[0], 1'b1};
        end
    end

    assign rstSync_n = rstPipe_q[1];

    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisation

    mixed_io_pkg::pins_t pinsRaw;
    mixed_io_pkg::pins_t pinsSync;

    // all field levels cross together through one synchroniser bundle
    // bits still settle independently, so two levels may show one edge apart
    assign pinsRaw.inPins = inPins;
    assign pinsRaw.outFeedback = outFeedback;
    assign pinsRaw.fault = faultPins;

    pin_sync #(
        .WIDTH($bits(mixed_io_pkg::pins_t))
    ) u_pin_sync (
        .mclk(mclk),
        .rstSync_n(rstSync_n),
        .ce(ce),
        .asyncIn(pinsRaw),
        .syncOut(pinsSync)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // functions

    // sensor short module flag from the per-slot flags
    function automatic logic sensorShortOf(input mixed_io_pkg::fault_t f);
        return |f.sensorShortSlot;
    endfunction

    // actuator short module flag from the channel errors
    function automatic logic actShortOf(input mixed_io_pkg::fault_t f);
        return |f.chanErr;
    endfunction

    // one code only; overload outranks supply, supply outranks device diagnosis
    // coexisting faults show only the strongest; the diagnostic word keeps the detail
    function automatic logic [7:0] errorCodeOf(input mixed_io_pkg::fault_t f);
        logic [7:0] code;
        code = `ERR_NONE;
        if (actShortOf(f) || sensorShortOf(f)) begin
            code = `ERR_OVERLOAD;
        end else if (f.lowSys || f.lowAct) begin
            code = `ERR_VOLTAGE;
        end else if (f.forcing || f.internal) begin
            code = `ERR_DEVICE;
        end
        return code;
    endfunction

    // four diagnostic bytes, byte 1 in the low eight bits
    function automatic logic [31:0] diagOf(input mixed_io_pkg::fault_t f);
        logic [7:0] modFlags;
        // bits 4 and 5 are never written, so they read zero
        modFlags = 8'h00;
        modFlags[`DIAG_LOW_SYS_BIT] = f.lowSys;
        modFlags[`DIAG_LOW_ACT_BIT] = f.lowAct;
        modFlags[`DIAG_SENSOR_SHORT_BIT] = sensorShortOf(f);
        modFlags[`DIAG_ACT_SHORT_BIT] = actShortOf(f);
        modFlags[`DIAG_FORCING_BIT] = f.forcing;
        modFlags[`DIAG_INTERNAL_BIT] = f.internal;
        // byte 2 per-slot shorts, byte 3 fixed, byte 4 channel errors
        return {f.chanErr, `DIAG_BYTE3_VALUE, f.sensorShortSlot, modFlags};
    endfunction

    // decode a requested mirror object; unknown codes flag as invalid
    function automatic logic mirrorValid(input logic [15:0] obj);
        return (obj == `OBJ_NONE) || (obj == `OBJ_MIR_BYTE) || (obj == `OBJ_MIR_BIT);
    endfunction

    // only meaningful for codes that mirrorValid accepted
    function automatic mixed_io_pkg::mirror_t mirrorOf(input logic [15:0] obj);
        mixed_io_pkg::mirror_t m;
        m = mixed_io_pkg::MIR_NONE;
        if (obj == `OBJ_MIR_BYTE) begin
            m = mixed_io_pkg::MIR_BYTE;
        end else if (obj == `OBJ_MIR_BIT) begin
            m = mixed_io_pkg::MIR_BIT;
        end
        return m;
    endfunction

    // concatenate the selected objects in order: input, mirror, error, diagnosis
    function automatic mixed_io_pkg::frame_t packImage(
        input logic [7:0] inB,
        input mixed_io_pkg::mirror_t mir,
        input logic [7:0] mirB,
        input logic errEn,
        input logic [7:0] err,
        input logic diagEn,
        input logic [31:0] dg
    );
        mixed_io_pkg::frame_t fr;
        logic [`LEN_W-1:0] idx;
        fr = '0;
        // input object always leads; byte and bit forms share one bit order
        fr.img[0] = inB;
        idx = `LEN_W'(1);
        // mirror is the real feedback, so a shorted channel shows its true level
        if (mir != mixed_io_pkg::MIR_NONE) begin
            fr.img[idx] = mirB;
            idx = idx + `LEN_W'(1);
        end
        // appendix order is fixed: error byte before the diagnostic bytes
        if (errEn) begin
            fr.img[idx] = err;
            idx = idx + `LEN_W'(1);
        end
        // diagnostic bytes go lowest first, byte 1 leading
        if (diagEn) begin
            for (int k = 0; k < 4; k++) begin
                fr.img[idx] = dg[8*k +: 8];
                idx = idx + `LEN_W'(1);
            end
        end
        fr.len = idx;
        return fr;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // state

    mixed_io_pkg::core_t core_q;
    mixed_io_pkg::core_t core_d;
    mixed_io_pkg::frame_t frame;
    logic cfgOk;
    logic [7:0] nextCmd;

    // mapping request legal only with known object codes for every part
    assign cfgOk = ((cfgIn.inObj == `OBJ_IN_BYTE) || (cfgIn.inObj == `OBJ_IN_BIT))
        && mirrorValid(cfgIn.mirObj)
        && ((cfgIn.outObj == `OBJ_OUT_BYTE) || (cfgIn.outObj == `OBJ_OUT_BIT));

    // byte form replaces all eight commands, bit form only the entries marked present
    // an empty mask in bit form leaves every channel as it was
    always_comb begin
        if (core_q.outFmt == mixed_io_pkg::FMT_BYTE) begin
            nextCmd = outByte;
        end else begin
            nextCmd = (core_q.cmd & ~outBitMask) | (outByte & outBitMask);
        end
    end

    // image built from the status registered one cycle earlier
    assign frame = packImage(pinsSync.inPins, core_q.mir, pinsSync.outFeedback,
        core_q.errEn, core_q.errCode, core_q.diagEn, core_q.diag);

    // next-state logic; ce low holds every field
    always_comb begin
        core_d = core_q;
        if (ce) begin
            core_d.txValid = 1'b0;
            core_d.cfgAccept = 1'b0;
            core_d.cfgReject = 1'b0;
            // status is recomputed each cycle, so a cleared cause clears its flag
            core_d.errCode = errorCodeOf(pinsSync.fault);
            core_d.diag = diagOf(pinsSync.fault);
            // mapping changes only between cycles so an image never mixes two layouts
            if (cfgWrite) begin
                if (cfgOk && core_q.st == mixed_io_pkg::ST_IDLE) begin
                    // both input forms share one bit order, so inFmt only records the choice
                    core_d.inFmt = (cfgIn.inObj == `OBJ_IN_BIT) ?
                        mixed_io_pkg::FMT_BIT : mixed_io_pkg::FMT_BYTE;
                    core_d.mir = mirrorOf(cfgIn.mirObj);
                    core_d.errEn = cfgIn.errEn;
                    core_d.diagEn = cfgIn.diagEn;
                    core_d.outFmt = (cfgIn.outObj == `OBJ_OUT_BIT) ?
                        mixed_io_pkg::FMT_BIT : mixed_io_pkg::FMT_BYTE;
                    core_d.cfgAccept = 1'b1;
                end else begin
                    core_d.cfgReject = 1'b1;
                end
            end
            // sequencer: take the command, let it settle one cycle, then publish
            case (core_q.st)
                mixed_io_pkg::ST_IDLE: begin
                    // strobes outside idle are dropped; the controller paces the cycle
                    if (pdStrobe) begin
                        core_d.cmd = nextCmd;
                        core_d.chanOut = nextCmd;
                        core_d.st = mixed_io_pkg::ST_APPLY;
                    end
                end
                mixed_io_pkg::ST_APPLY: begin
                    // limitation: feedback crosses two flops, so the mirror shows the earlier drive
                    core_d.st = mixed_io_pkg::ST_PUBLISH;
                end
                mixed_io_pkg::ST_PUBLISH: begin
                    core_d.img = frame.img;
                    core_d.len = frame.len;
                    core_d.txValid = 1'b1;
                    core_d.st = mixed_io_pkg::ST_IDLE;
                end
                default: begin
                    core_d.st = mixed_io_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // all-zero reset: idle, byte input, no mirror, no appendix, byte output, outputs off
    // mapping and drive fall back together, so no image of the old layout survives
    always_ff @(posedge mclk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            core_q <= '0;
        end else begin
            core_q <= core_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs, each straight from the state register

    assign cfgAccept = core_q.cfgAccept;
    assign cfgReject = core_q.cfgReject;
    assign txValid = core_q.txValid;
    assign txImage = core_q.img;
    assign txLength = core_q.len;
    assign errorCode = core_q.errCode;
    assign diagWord = core_q.diag;
    assign chanOut = core_q.chanOut;

endmodule // mixed_io_process_image

/* File: verif/mixed_io_process_image_assertions.sv */
// port checker of the process-image core
`timescale 1ns/1ps

module mixed_io_process_image_assertions (
    // clock, reset, enable
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ce,
    // mapping and process data
    input wire logic cfgWrite,
    input wire logic cfgAccept,
    input wire logic cfgReject,
    input wire logic pdStrobe,
    input wire logic txValid,
    // status and pins
    input wire logic [7:0] errorCode,
    input wire logic [31:0] diagWord,
    input wire mixed_io_pkg::fault_t faultPins
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);

    ////////////////////////////////////////////////////////////////////////////
    // one code only: overload beats supply, supply beats forcing or internal fault
    logic [7:0] codeExp;
    assign codeExp = (diagWord[2] | diagWord[3]) ? 8'h03 :
        (diagWord[1:0] != 2'b00) ? 8'h05 : (diagWord[7:6] != 2'b00) ? 8'h81 : 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    cfg_answer_a: assert property (ce && cfgWrite |=> cfgAccept != cfgReject)
        else $error("mapping request not answered once");
    cfg_quiet_a: assert property (ce && !cfgWrite |=> !cfgAccept && !cfgReject)
        else $error("mapping answer without request");
    tx_cause_a: assert property (txValid |-> $past(pdStrobe, 3))
        else $error("image without a strobe three edges before");
    tx_pulse_a: assert property (txValid |=> !txValid)
        else $error("image valid longer than one cycle");
    err_code_a: assert property (errorCode == codeExp)
        else $error("error byte disagrees with module flags");
    diag_zero_a: assert property (diagWord[23:16] == 8'h00 && diagWord[5:4] == 2'b00)
        else $error("reserved diagnostic bits set");
    short_or_a: assert property (diagWord[2] == |diagWord[15:8] &&
        diagWord[3] == |diagWord[31:24])
        else $error("short flag disagrees with per-slot flags");
    slot_follow_a: assert property (diagWord[31:24] == $past(faultPins.chanErr, 3) &&
        diagWord[15:8] == $past(faultPins.sensorShortSlot, 3))
        else $error("slot flags do not follow the pins");
    supply_follow_a: assert property (diagWord[0] == $past(faultPins.lowSys, 3) &&
        diagWord[1] == $past(faultPins.lowAct, 3))
        else $error("supply flags do not follow the pins");
    module_follow_a: assert property (diagWord[6] == $past(faultPins.forcing, 3) &&
        diagWord[7] == $past(faultPins.internal, 3))
        else $error("forcing or internal flag does not follow the pins");

    // main scenarios reached
    cover property (txValid);
    cover property (cfgReject);
    cover property (errorCode == 8'h81);
endmodule // mixed_io_process_image_assertions

bind mixed_io_process_image mixed_io_process_image_assertions u_checker (.mclk, .rst_n, .ce,
    .cfgWrite, .cfgAccept, .cfgReject, .pdStrobe, .txValid, .errorCode, .diagWord, .faultPins);

/* File: verif/field_master_model.sv */
// controller model: mapping requests and cyclic output data
`timescale 1ns/1ps

module field_master_model (
    // clock
    input wire logic mclk,
    // mapping
    output mixed_io_pkg::cfg_t cfgIn,
    output logic cfgWrite,
    input wire logic cfgAccept,
    input wire logic cfgReject,
    // process data
    output logic pdStrobe,
    output logic [7:0] outByte,
    output logic [7:0] outBitMask
);
    // quiet at time zero
    initial begin
        cfgWrite = 1'b0;
        pdStrobe = 1'b0;
        cfgIn = '0;
        outByte = 8'h00;
        outBitMask = 8'h00;
    end

    // one mapping request; answer {accept, reject} read in the cycle after the take
    task automatic map(input mixed_io_pkg::cfg_t c, output logic [1:0] ans);
        @(posedge mclk);
        #1;
        cfgWrite = 1'b1;
        cfgIn = c;
        @(posedge mclk);
        #1;
        cfgWrite = 1'b0;
        cfgIn = ~c; // released fields carry no stale value
        ans = {cfgAccept, cfgReject};
    endtask

    // one process-data cycle; data lines are inverted once the strobe drops
    task automatic cycle(input logic [7:0] b, input logic [7:0] m);
        @(posedge mclk);
        #1;
        pdStrobe = 1'b1;
        outByte = b;
        outBitMask = m;
        @(posedge mclk);
        #1;
        pdStrobe = 1'b0;
        outByte = ~b;
        outBitMask = ~m;
    endtask
endmodule // field_master_model

/* File: verif/mixed_io_process_image_test.sv */
// self-checking bench of the process-image core
`timescale 1ns/1ps
`define CHK(what, exp, got) begin compares++; if ((got) !== (exp)) begin num_errors++; \
    $display("BAD %s expected %0h seen %0h", what, exp, got); end end

module mixed_io_process_image_test;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic [7:0] inPins = 8'h81;
    logic [7:0] fieldOut = 8'h00;
    mixed_io_pkg::fault_t faults = '0;
    mixed_io_pkg::cfg_t cfgIn;
    logic cfgWrite, cfgAccept, cfgReject, pdStrobe, txValid;
    logic [7:0] outByte, outBitMask, errorCode, chanOut;
    logic [31:0] diagWord;
    mixed_io_pkg::image_t txImage;
    logic [2:0] txLength;
    int num_errors = 0;
    int compares = 0;

    always #2 mclk = ~mclk;

    mixed_io_process_image u_mixed_io_process_image (.mclk, .rst_n, .ce, .cfgWrite, .cfgIn,
        .cfgAccept, .cfgReject, .pdStrobe, .outByte, .outBitMask, .txValid, .txImage,
        .txLength, .errorCode, .diagWord, .inPins, .outFeedback(fieldOut),
        .faultPins(faults), .chanOut);
    field_master_model u_field_master_model (.mclk, .cfgIn, .cfgWrite, .cfgAccept,
        .cfgReject, .pdStrobe, .outByte, .outBitMask);

    ////////////////////////////////////////////////////////////////////////////
    // expected flags: module byte, per-slot sensor byte, zero byte, channel errors
    function automatic logic [31:0] diag_of(mixed_io_pkg::fault_t f);
        return {f.chanErr, 8'h00, f.sensorShortSlot, f.internal, f.forcing, 2'b00,
            |f.chanErr, |f.sensorShortSlot, f.lowAct, f.lowSys};
    endfunction
    // one code only, overload first
    function automatic logic [7:0] err_of(mixed_io_pkg::fault_t f);
        if (f.chanErr != 0 || f.sensorShortSlot != 0) return 8'h03;
        if (f.lowSys || f.lowAct) return 8'h05;
        if (f.forcing || f.internal) return 8'h81;
        return 8'h00;
    endfunction
    function automatic mixed_io_pkg::cfg_t mk(logic [15:0] i, logic [15:0] m, logic e,
        logic d, logic [15:0] o);
        return mixed_io_pkg::cfg_t'({i, m, e, d, o});
    endfunction

    // one cycle, then the fresh image is compared byte by byte
    task automatic run_image(input logic [7:0] b, input logic [7:0] exp[$]);
        int n;
        u_field_master_model.cycle(b, 8'hFF);
        n = 0;
        while (txValid !== 1'b1 && n < 8) begin
            @(posedge mclk);
            #1;
            n++;
        end
        `CHK("image delay", 2, n)
        `CHK("image length", 3'(exp.size()), txLength)
        foreach (exp[i]) `CHK("image byte", exp[i], txImage[i])
        repeat (2) @(posedge mclk);
        #1;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // input forms, mirror forms and appendices in sixteen mixed combinations
    task automatic t_mapping();
        logic [1:0] ans;
        logic [31:0] d;
        logic [7:0] q[$];
        logic [15:0] mirTab[3] = '{16'h0000, 16'h1A02, 16'h1A03};
        faults = 20'h00180;
        for (int i = 0; i < 16; i++) begin
            u_field_master_model.map(mk(i[0] ? 16'h1A01 : 16'h1A00, mirTab[i % 3], i[2],
                i[3], 16'h1600), ans);
            `CHK("map answer", 2'b10, ans)
            inPins = 8'hC3 ^ 8'(i);
            fieldOut = 8'h3C ^ 8'(i * 17);
            repeat (4) @(posedge mclk);
            #1;
            d = diag_of(faults);
            q = '{inPins};
            if (i % 3 != 0) q.push_back(fieldOut);
            if (i[2]) q.push_back(err_of(faults));
            if (i[3]) q = {q, d[7:0], d[15:8], d[23:16], d[31:24]};
            run_image(8'h00, q);
        end
        $display("test mapping done");
    endtask

    // byte and bit output forms
    task automatic t_output();
        logic [1:0] ans;
        u_field_master_model.map(mk(16'h1A00, 16'h0000, 1'b0, 1'b0, 16'h1600), ans);
        `CHK("map answer", 2'b10, ans)
        u_field_master_model.cycle(8'hA5, 8'h00);
        `CHK("byte drive", 8'hA5, chanOut)
        repeat (4) @(posedge mclk);
        u_field_master_model.map(mk(16'h1A00, 16'h0000, 1'b0, 1'b0, 16'h1601), ans);
        `CHK("map answer", 2'b10, ans)
        u_field_master_model.cycle(8'h0F, 8'h3C);
        `CHK("bit drive", 8'h8D, chanOut)
        repeat (4) @(posedge mclk);
        #1;
        // with the enable low a strobe must leave the drive untouched
        ce = 1'b0;
        u_field_master_model.cycle(8'h77, 8'hFF);
        `CHK("frozen drive", 8'h8D, chanOut)
        ce = 1'b1;
        repeat (4) @(posedge mclk);
        $display("test output done");
    endtask

    // bad codes, strobe and mapping while a cycle is in flight
    task automatic t_refuse();
        logic [1:0] ans;
        int cnt;
        mixed_io_pkg::cfg_t bad[3];
        bad[0] = mk(16'h1A05, 16'h0000, 1'b0, 1'b0, 16'h1600);
        bad[1] = mk(16'h1A00, 16'h1A00, 1'b0, 1'b0, 16'h1600);
        bad[2] = mk(16'h1A00, 16'h0000, 1'b0, 1'b0, 16'h1A00);
        foreach (bad[k]) begin
            u_field_master_model.map(bad[k], ans);
            `CHK("bad code", 2'b01, ans)
        end
        u_field_master_model.cycle(8'h11, 8'hFF);
        u_field_master_model.cycle(8'h22, 8'hFF);
        `CHK("held drive", 8'h11, chanOut)
        cnt = 0;
        repeat (6) begin
            cnt += txValid;
            @(posedge mclk);
            #1;
        end
        `CHK("one image", 1, cnt)
        u_field_master_model.cycle(8'h33, 8'hFF);
        u_field_master_model.map(mk(16'h1A01, 16'h1A02, 1'b1, 1'b1, 16'h1600), ans);
        `CHK("busy map", 2'b01, ans)
        repeat (4) @(posedge mclk);
        #1;
        run_image(8'h44, '{inPins});
        $display("test refuse done");
    endtask

    // each fault alone, all together, then cleared again
    task automatic t_faults();
        logic [19:0] ftab[9] = '{20'h00000, 20'h00080, 20'h00100, 20'h80000, 20'h40000,
            20'h20000, 20'h10000, 20'hFFFFF, 20'h00000};
        foreach (ftab[k]) begin
            faults = ftab[k];
            repeat (5) @(posedge mclk);
            #1;
            `CHK("error byte", err_of(faults), errorCode)
            `CHK("diag word", diag_of(faults), diagWord)
        end
        $display("test faults done");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // reset mapping gives the input byte only, outputs off
    task automatic t_reset();
        repeat (8) @(posedge mclk);
        #1;
        rst_n = 1'b1;
        `CHK("drive after reset", 8'h00, chanOut)
        repeat (6) @(posedge mclk);
        #1;
        run_image(8'h00, '{8'h81});
        $display("test reset done");
    endtask

    // main sequence
    initial begin
        t_reset();
        t_mapping();
        t_output();
        t_refuse();
        t_faults();
        print_verdict();
    end

    // hang guard, several times the expected run
    initial begin
        #20000;
        num_errors++;
        print_verdict();
    end
endmodule // mixed_io_process_image_test
